// ==== hdl/ectm_pkg.sv ====
// Functional notes
// [RL1] 8-bit upcounter, prescaler cpu/2,/4,/8, slow/8000
// [RL2] Counter writes reload counter with FCh
// [RL3] Counter resets to FCh, only reload value
// [RL4] Wrap FFh to 00h sets overflow flag
// [RL5] Overflow irq needs enable and clear mask
// [RL6] Status read then counter access clears overflow
// [RL7] Shadow counter access never clears overflow
// [RL8] Runs in wait, freezes in halt
// [RL9] Selected capture edge latches count, sets flag
// [RL10] One capture enable, gated by global mask
// [RL11] Status read then capture access clears flag
// [RL12] Capture registers read-only, newest capture wins
// [RL13] Pulse modes: only capture channel two works
// [RL14] Capture inputs always connected to timer
// [RL15] Unbonded timer inputs read as one
// [RL16] Compare registers match counter, set flag
// [RL17] Match drives enabled pin to level; reset low
// [RL18] One compare enable, gated by global mask
// [RL19] Compare registers software-only, reset zero
// [RL20] Clock select codes mapped and documented
package ectm_pkg;
	localparam logic [7:0] ECTM_RELOAD      = 8'hfc;
	localparam logic [7:0] ECTM_CMP_RESET   = 8'h00;
	localparam int         ECTM_SLOW_DIV    = 8000;
	localparam logic [1:0] ECTM_CS_DIV4     = 2'h0;
	localparam logic [1:0] ECTM_CS_DIV2     = 2'h1;
	localparam logic [1:0] ECTM_CS_DIV8     = 2'h2;
	localparam logic [1:0] ECTM_CS_SLOW     = 2'h3;
	localparam int         ECTM_DIV2        = 2;
	localparam int         ECTM_DIV4        = 4;
	localparam int         ECTM_DIV8        = 8;
	localparam int         ECTM_PRE_W       = 13;
endpackage : ectm_pkg

// ==== hdl/ectm_tick_if.sv ====
`timescale 1ns/10ps
interface ectm_tick_if;
	logic       tick;
	logic       reload;
	logic       run;
	logic [1:0] clock_select_field;
	modport src (output tick, input reload, input run, input clock_select_field);
	modport dst (input tick, output reload, output run, output clock_select_field);
endinterface : ectm_tick_if

// ==== hdl/ectm_prescaler.sv ====
`timescale 1ns/10ps
module ectm_prescaler
	import ectm_pkg::*;
#(
	parameter int SLOW_DIV = ECTM_SLOW_DIV
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic slow_oscillator_tick,
	ectm_tick_if.src  tk
);
	if (SLOW_DIV < 1 || SLOW_DIV >= (1 << ECTM_PRE_W)) begin : g_bad_div
		$error("SLOW_DIV out of range");
	end

	logic [ECTM_PRE_W-1:0] pre_reg;
	logic [ECTM_PRE_W-1:0] limit;
	logic                  step;
	logic                  tick_reg;

	always_comb begin
		limit = ECTM_PRE_W'(ECTM_DIV4 - 1);
		step  = 1'b1;
		case (tk.clock_select_field) // RL1 RL20
			ECTM_CS_DIV2: limit = ECTM_PRE_W'(ECTM_DIV2 - 1);
			ECTM_CS_DIV8: limit = ECTM_PRE_W'(ECTM_DIV8 - 1);
			ECTM_CS_SLOW: begin
				limit = ECTM_PRE_W'(SLOW_DIV - 1);
				step  = slow_oscillator_tick;
			end
			default: limit = ECTM_PRE_W'(ECTM_DIV4 - 1);
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pre_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (tk.reload) begin
			pre_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (!tk.run || !step) begin // RL8
			tick_reg <= 1'b0;
		end else if (pre_reg >= limit) begin
			pre_reg  <= '0;
			tick_reg <= 1'b1;
		end else begin
			pre_reg  <= pre_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	assign tk.tick = tick_reg;
endmodule : ectm_prescaler

// ==== hdl/ectm_timer.sv ====
`timescale 1ns/10ps
module ectm_timer
	import ectm_pkg::*;
#(
	parameter int SLOW_DIV = ECTM_SLOW_DIV
) (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       halt_mode,
	input  wire logic       global_irq_mask,
	input  wire logic       slow_oscillator_tick,
	input  wire logic [1:0] clock_select_field,
	input  wire logic       pulse_mode_active,
	input  wire logic       overflow_irq_enable,
	input  wire logic       capture_irq_enable,
	input  wire logic       compare_irq_enable,
	input  wire logic [1:0] capture_edge_select,
	input  wire logic [1:0] compare_pin_enable,
	input  wire logic [1:0] compare_output_level,
	input  wire logic [1:0] capture_input_pin,
	input  wire logic [1:0] capture_pin_bonded,
	input  wire logic       status_read,
	input  wire logic       main_counter_access,
	input  wire logic       main_counter_write,
	input  wire logic       shadow_counter_write,
	input  wire logic [1:0] capture_access,
	input  wire logic [1:0] compare_access,
	input  wire logic [1:0] compare_write,
	input  wire logic [7:0] write_data,
	output logic      [7:0] main_counter_reg,
	output logic      [7:0] shadow_counter_reg,
	output logic      [7:0] capture_value_reg_1,
	output logic      [7:0] capture_value_reg_2,
	output logic      [7:0] compare_value_reg_1,
	output logic      [7:0] compare_value_reg_2,
	output logic      [4:0] timer_status_reg,
	output logic      [1:0] compare_output_pin,
	output logic            timer_irq
);
	ectm_tick_if tk ();

	logic [7:0] cnt_reg;
	logic [1:0] cap_s1_reg;
	logic [1:0] cap_s2_reg;
	logic [1:0] cap_d_reg;
	logic [1:0] cap_in;
	logic [1:0] cap_evt;
	logic       overflow_flag_reg;
	logic [1:0] capture_flag_reg;
	logic [1:0] compare_flag_reg;
	logic       ovf_arm_reg;
	logic [1:0] cap_arm_reg;
	logic [1:0] cmp_arm_reg;
	logic       reload;
	logic       wrap;
	logic [1:0] match;
	logic [1:0] cap_en;

	assign reload = main_counter_write | shadow_counter_write; // RL2
	assign tk.reload = reload;
	assign tk.run = ~halt_mode; // RL8
	assign tk.clock_select_field = clock_select_field;

	ectm_prescaler #(
		.SLOW_DIV (SLOW_DIV)
	) u_pre (
		.clock                (clock),
		.resetn               (resetn),
		.slow_oscillator_tick (slow_oscillator_tick),
		.tk                   (tk)
	);

	// Counter
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= ECTM_RELOAD; // RL3
		end else if (reload) begin
			cnt_reg <= ECTM_RELOAD; // RL2
		end else if (tk.tick) begin
			cnt_reg <= cnt_reg + 8'h01; // RL1
		end
	end

	assign wrap = tk.tick & ~reload & (cnt_reg == 8'hff); // RL4

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			main_counter_reg   <= ECTM_RELOAD; // RL3
			shadow_counter_reg <= ECTM_RELOAD;
		end else begin
			main_counter_reg   <= cnt_reg;
			shadow_counter_reg <= cnt_reg;
		end
	end

	// Capture pin synchronisers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cap_s1_reg <= 2'h3;
			cap_s2_reg <= 2'h3;
			cap_d_reg  <= 2'h3;
		end else begin
			cap_s1_reg <= capture_input_pin;
			cap_s2_reg <= cap_s1_reg;
			cap_d_reg  <= cap_in;
		end
	end

	assign cap_in = cap_s2_reg | ~capture_pin_bonded; // RL15
	assign cap_en = {1'b1, ~pulse_mode_active}; // RL13

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// Edge seen regardless of pin direction RL14
			cap_evt[i] = cap_en[i] & (capture_edge_select[i] ?
				(cap_in[i] & ~cap_d_reg[i]) :
				(~cap_in[i] & cap_d_reg[i])); // RL9
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			capture_value_reg_1 <= 8'h00;
		end else if (cap_evt[0]) begin
			capture_value_reg_1 <= cnt_reg; // RL12
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			capture_value_reg_2 <= 8'h00;
		end else if (cap_evt[1]) begin
			capture_value_reg_2 <= cnt_reg; // RL12
		end
	end

	// Compare registers, software only
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			compare_value_reg_1 <= ECTM_CMP_RESET; // RL19
			compare_value_reg_2 <= ECTM_CMP_RESET;
		end else begin
			if (compare_write[0])
				compare_value_reg_1 <= write_data;
			if (compare_write[1])
				compare_value_reg_2 <= write_data;
		end
	end

	assign match[0] = tk.tick & (cnt_reg == compare_value_reg_1); // RL16
	assign match[1] = tk.tick & (cnt_reg == compare_value_reg_2);

	// Arming by status read while flag set
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ovf_arm_reg <= 1'b0;
		end else if (status_read && overflow_flag_reg) begin
			ovf_arm_reg <= 1'b1; // RL6
		end else if (main_counter_access) begin
			ovf_arm_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cap_arm_reg <= 2'h0;
			cmp_arm_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (status_read && capture_flag_reg[i])
					cap_arm_reg[i] <= 1'b1; // RL11
				else if (capture_access[i])
					cap_arm_reg[i] <= 1'b0;
				if (status_read && compare_flag_reg[i])
					cmp_arm_reg[i] <= 1'b1;
				else if (compare_access[i])
					cmp_arm_reg[i] <= 1'b0;
			end
		end
	end

	// Flags: set wins over clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			overflow_flag_reg <= 1'b0;
		end else if (wrap) begin
			overflow_flag_reg <= 1'b1; // RL4
		end else if (ovf_arm_reg && main_counter_access) begin
			overflow_flag_reg <= 1'b0; // RL6 RL7
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			capture_flag_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (cap_evt[i])
					capture_flag_reg[i] <= 1'b1; // RL9
				else if (cap_arm_reg[i] && capture_access[i])
					capture_flag_reg[i] <= 1'b0; // RL11
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			compare_flag_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (match[i])
					compare_flag_reg[i] <= 1'b1; // RL16
				else if (cmp_arm_reg[i] && compare_access[i])
					compare_flag_reg[i] <= 1'b0;
			end
		end
	end

	always_comb begin
		timer_status_reg = {capture_flag_reg[0], compare_flag_reg[0],
			overflow_flag_reg, capture_flag_reg[1], compare_flag_reg[1]};
	end

	// Compare output pins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			compare_output_pin <= 2'h0; // RL17
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (match[i] && compare_pin_enable[i])
					compare_output_pin[i] <= compare_output_level[i]; // RL17
			end
		end
	end

	// Pending request held until enabled and unmasked
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= ~global_irq_mask &
				((overflow_flag_reg & overflow_irq_enable) | // RL5
				(|capture_flag_reg & capture_irq_enable) | // RL10
				(|compare_flag_reg & compare_irq_enable)); // RL18
		end
	end
endmodule : ectm_timer

// ==== tb/ectm_timer_props.sv ====
`timescale 1ns/10ps
module ectm_timer_props (
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       halt_mode,
	input wire logic       global_irq_mask,
	input wire logic       overflow_irq_enable,
	input wire logic       main_counter_write,
	input wire logic       shadow_counter_write,
	input wire logic       main_counter_access,
	input wire logic [1:0] compare_write,
	input wire logic [7:0] write_data,
	input wire logic [7:0] main_counter_reg,
	input wire logic [7:0] shadow_counter_reg,
	input wire logic [7:0] compare_value_reg_1,
	input wire logic [4:0] timer_status_reg,
	input wire logic       timer_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_wrap;
		main_counter_reg == 8'hff ##1 main_counter_reg == 8'h00;
	endsequence
	sequence s_frozen;
		(halt_mode && !main_counter_write && !shadow_counter_write) [*4];
	endsequence
	property p_wrap; s_wrap |-> timer_status_reg[2]; endproperty
	property p_reload;
		main_counter_write || shadow_counter_write
		|-> ##[1:2] main_counter_reg == 8'hfc;
	endproperty
	property p_views; shadow_counter_reg == main_counter_reg; endproperty
	property p_irq;
		(timer_status_reg[2] && overflow_irq_enable && !global_irq_mask) [*2]
		|-> timer_irq;
	endproperty
	property p_mask; global_irq_mask [*2] |-> !timer_irq; endproperty
	property p_keep;
		timer_status_reg[2] && shadow_counter_write && !main_counter_access
		|=> timer_status_reg[2];
	endproperty
	property p_halt; s_frozen |-> $stable(main_counter_reg); endproperty
	property p_cmp_wr;
		compare_write[0] |=> compare_value_reg_1 == $past(write_data);
	endproperty
	a_wrap: assert property (p_wrap) else $error("no overflow flag");
	a_reload: assert property (p_reload) else $error("no reload");
	a_views: assert property (p_views) else $error("views differ");
	a_irq: assert property (p_irq) else $error("irq missing");
	a_mask: assert property (p_mask) else $error("irq when masked");
	a_keep: assert property (p_keep) else $error("flag lost");
	a_halt: assert property (p_halt) else $error("count in halt");
	a_cmp_wr: assert property (p_cmp_wr) else $error("bad write");
endmodule : ectm_timer_props
bind ectm_timer ectm_timer_props i_ectm_timer_props (.clock(clock),
	.resetn(resetn), .halt_mode(halt_mode),
	.global_irq_mask(global_irq_mask),
	.overflow_irq_enable(overflow_irq_enable),
	.main_counter_write(main_counter_write),
	.shadow_counter_write(shadow_counter_write),
	.main_counter_access(main_counter_access),
	.compare_write(compare_write), .write_data(write_data),
	.main_counter_reg(main_counter_reg),
	.shadow_counter_reg(shadow_counter_reg),
	.compare_value_reg_1(compare_value_reg_1),
	.timer_status_reg(timer_status_reg), .timer_irq(timer_irq));

// ==== tb/ectm_pin_model.sv ====
`timescale 1ns/10ps
module ectm_pin_model (
	input  wire logic       clock,
	input  wire logic [1:0] flip,
	output logic      [1:0] capture_input_pin
);
	initial capture_input_pin = 2'h3;
	// External source toggles a pin on command
	always @(posedge clock) begin
		capture_input_pin <= capture_input_pin ^ flip;
	end
endmodule : ectm_pin_model

// ==== tb/test_eight_bit_capture_compare_timer.sv ====
`timescale 1ns/10ps
module test_eight_bit_capture_compare_timer;
	import ectm_pkg::*;
	logic       clock = 0, resetn = 0, halt_mode = 0, global_irq_mask = 0;
	logic       slow_oscillator_tick = 0, pulse_mode_active = 0;
	logic       overflow_irq_enable = 0, capture_irq_enable = 0;
	logic       compare_irq_enable = 0, status_read = 0, timer_irq;
	logic       main_counter_access = 0, main_counter_write = 0;
	logic       shadow_counter_write = 0;
	logic [1:0] clock_select_field = 2'h1, capture_edge_select = 2'h0;
	logic [1:0] compare_pin_enable = 2'h0, compare_output_level = 2'h0;
	logic [1:0] capture_pin_bonded = 2'h3, capture_access = 2'h0;
	logic [1:0] compare_access = 2'h0, compare_write = 2'h0, flip = 2'h0;
	logic [1:0] capture_input_pin, compare_output_pin;
	logic [7:0] write_data = 8'h00, main_counter_reg, shadow_counter_reg;
	logic [7:0] cap1, cap2, cmp1, cmp2;
	logic [4:0] timer_status_reg;
	int         n_fail = 0, n_checks = 0;
	always #4 clock = ~clock;
	always @(negedge clock) slow_oscillator_tick <= ~slow_oscillator_tick;
	ectm_pin_model i_ectm_pin_model (.clock(clock), .flip(flip),
		.capture_input_pin(capture_input_pin));
	ectm_timer #(.SLOW_DIV(4)) i_ectm_timer (.clock(clock), .resetn(resetn),
		.halt_mode(halt_mode), .global_irq_mask(global_irq_mask),
		.slow_oscillator_tick(slow_oscillator_tick),
		.clock_select_field(clock_select_field),
		.pulse_mode_active(pulse_mode_active),
		.overflow_irq_enable(overflow_irq_enable),
		.capture_irq_enable(capture_irq_enable),
		.compare_irq_enable(compare_irq_enable),
		.capture_edge_select(capture_edge_select),
		.compare_pin_enable(compare_pin_enable),
		.compare_output_level(compare_output_level),
		.capture_input_pin(capture_input_pin),
		.capture_pin_bonded(capture_pin_bonded), .status_read(status_read),
		.main_counter_access(main_counter_access),
		.main_counter_write(main_counter_write),
		.shadow_counter_write(shadow_counter_write),
		.capture_access(capture_access), .compare_access(compare_access),
		.compare_write(compare_write), .write_data(write_data),
		.main_counter_reg(main_counter_reg),
		.shadow_counter_reg(shadow_counter_reg),
		.capture_value_reg_1(cap1), .capture_value_reg_2(cap2),
		.compare_value_reg_1(cmp1), .compare_value_reg_2(cmp2),
		.timer_status_reg(timer_status_reg),
		.compare_output_pin(compare_output_pin), .timer_irq(timer_irq));
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic pulse(ref logic s);
		@(negedge clock) s = 1'b1;
		@(negedge clock) s = 1'b0;
	endtask : pulse
	task flip_pin(input logic [1:0] m);
		@(negedge clock) flip = m;
		@(negedge clock) flip = 2'h0;
	endtask : flip_pin
	task wait_flag(input int b);
		for (int k = 0; k < 3000 && timer_status_reg[b] !== 1'b1; k++)
			@(negedge clock);
		repeat (2) @(negedge clock);
	endtask : wait_flag
	task t_reset;
		chk("count", 8'hfc, main_counter_reg);
		chk("compare", 8'h00, cmp1);
		chk("status", 8'h00, {3'h0, timer_status_reg});
		chk("pins", 8'h00, {6'h0, compare_output_pin});
	endtask : t_reset
	task t_clock;
		logic [7:0] v;
		logic [7:0] per [4] = '{8'h4, 8'h2, 8'h8, 8'h8};
		int n;
		for (int c = 0; c < 4; c++) begin
			clock_select_field = c[1:0];
			repeat (20) @(negedge clock);
			v = main_counter_reg;
			for (n = 0; n < 40 && main_counter_reg === v; n++) @(negedge clock);
			v = main_counter_reg;
			for (n = 0; n < 40 && main_counter_reg === v; n++) @(negedge clock);
			chk("period", per[c], n[7:0]);
		end
		clock_select_field = 2'h1;
	endtask : t_clock
	task t_ovf;
		overflow_irq_enable = 1;
		global_irq_mask = 1;
		wait_flag(2);
		chk("irq masked", 8'h00, {7'h0, timer_irq});
		global_irq_mask = 0;
		repeat (3) @(negedge clock);
		chk("irq", 8'h01, {7'h0, timer_irq});
		halt_mode = 1;
		pulse(status_read);
		pulse(shadow_counter_write);
		repeat (3) @(negedge clock);
		chk("reload", 8'hfc, main_counter_reg);
		chk("ovf kept", 8'h01, {7'h0, timer_status_reg[2]});
		pulse(status_read);
		pulse(main_counter_access);
		repeat (3) @(negedge clock);
		chk("ovf clear", 8'h00, {7'h0, timer_status_reg[2]});
	endtask : t_ovf
	task t_cap;
		capture_edge_select = 2'h3;
		capture_irq_enable = 1;
		flip_pin(2'h2);
		flip_pin(2'h2);
		wait_flag(1);
		chk("cap2", 8'hfc, cap2);
		chk("cap irq", 8'h01, {7'h0, timer_irq});
		pulse_mode_active = 1;
		flip_pin(2'h1);
		flip_pin(2'h1);
		repeat (6) @(negedge clock);
		chk("cap1 off", 8'h00, {7'h0, timer_status_reg[4]});
		pulse_mode_active = 0;
		flip_pin(2'h1);
		repeat (6) @(negedge clock);
		capture_pin_bonded = 2'h2;
		wait_flag(4);
		chk("cap1", 8'hfc, cap1);
		pulse(status_read);
		@(negedge clock) capture_access = 2'h1;
		@(negedge clock) capture_access = 2'h0;
		repeat (2) @(negedge clock);
		chk("cap clear", 8'h0b, {3'h0, timer_status_reg});
	endtask : t_cap
	task t_cmp;
		halt_mode = 0;
		compare_pin_enable = 2'h1;
		compare_output_level = 2'h1;
		@(negedge clock) write_data = 8'h10;
		compare_write = 2'h1;
		@(negedge clock) compare_write = 2'h0;
		chk("cmp1", 8'h10, cmp1);
		pulse(status_read);
		@(negedge clock) compare_access = 2'h1;
		@(negedge clock) compare_access = 2'h0;
		chk("cmp clear", 8'h00, {7'h0, timer_status_reg[3]});
		wait_flag(3);
		chk("cmp flag", 8'h01, {7'h0, timer_status_reg[3]});
		chk("pins", 8'h01, {6'h0, compare_output_pin});
	endtask : t_cmp
	task finish_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge clock);
		@(negedge clock) resetn = 1;
		t_reset;
		t_clock;
		t_ovf;
		t_cap;
		t_cmp;
		finish_test;
	end
endmodule : test_eight_bit_capture_compare_timer
